/* File: shared/cbma_pkg.sv */
// Package with register map, fields and widths for the circular buffer addressing block
package cbma_pkg;
    localparam int unsigned DW = 16;
    localparam int unsigned AW = 3;
    localparam int unsigned WREG_W = 4;
    // Register indices on the plain register port
    localparam logic [2:0] REG_CONTROL = 3'h0;
    localparam logic [2:0] REG_X_START = 3'h1;
    localparam logic [2:0] REG_X_END = 3'h2;
    localparam logic [2:0] REG_Y_START = 3'h3;
    localparam logic [2:0] REG_Y_END = 3'h4;
    localparam logic [2:0] REG_STATUS = 3'h5;
    // Control field positions
    localparam int unsigned X_SEL_LSB = 0;
    localparam int unsigned Y_SEL_LSB = 4;
    localparam int unsigned Y_EN_BIT = 14;
    localparam int unsigned X_EN_BIT = 15;
    localparam logic [3:0] SEL_NONE = 4'hf;
    // Reset values
    localparam logic [15:0] CONTROL_RST = 16'h00ff;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // Y word alignment mask, clears address bit 0
    localparam logic [15:0] WORD_MASK = 16'hfffe;
    // Largest buffer span in bytes minus one (32K words)
    localparam logic [15:0] MAX_SPAN = 16'hffff;
    // Writable control bits: enables and both selection fields
    localparam logic [15:0] CONTROL_MASK = 16'hc0ff;
    typedef enum logic [2:0] {
        CBMA_IDLE = 3'b001,
        CBMA_WRAP_HI = 3'b010,
        CBMA_WRAP_LO = 3'b100
    } cbma_wrap_t;
endpackage : cbma_pkg

/* File: logic/cbma_wrap.sv */
// One address generator lane: applies circular wrap to a pointer update
`timescale 1ns/1ps
module cbma_wrap
    import cbma_pkg::*;
#(
    parameter int unsigned W = 16
) (
    input wire logic [W-1:0] cur_addr,
    input wire logic [W-1:0] step,
    input wire logic dec,
    input wire logic active,
    input wire logic word_only,
    input wire logic [W-1:0] buf_start,
    input wire logic [W-1:0] buf_end,
    output logic [W-1:0] new_addr,
    output cbma_wrap_t wrap_kind
);
    logic [W-1:0] raw;
    logic [W-1:0] lo;
    logic [W-1:0] hi;
    logic [W-1:0] unit;
    // Smallest access: one byte in X, one word in Y
    localparam logic [W-1:0] BYTE_UNIT = 1;
    localparam logic [W-1:0] WORD_UNIT = 2;
    // Wrap decision; an increment checks only the end bound and a decrement only the start bound
    always_comb begin
        // Overshoot is counted in access units so a word lane never lands on an odd byte
        unit = word_only ? WORD_UNIT : BYTE_UNIT;
        lo = word_only ? (buf_start & WORD_MASK[W-1:0]) : buf_start;
        hi = word_only ? (buf_end & WORD_MASK[W-1:0]) : buf_end;
        raw = dec ? cur_addr - step : cur_addr + step;
        if (word_only) begin
            raw = raw & WORD_MASK[W-1:0];
        end
        new_addr = raw;
        wrap_kind = CBMA_IDLE;
        if (active && !dec && raw > hi) begin
            new_addr = lo + (raw - hi - unit);
            wrap_kind = CBMA_WRAP_HI;
        end else if (active && dec && raw < lo) begin
            new_addr = hi - (lo - raw - unit);
            wrap_kind = CBMA_WRAP_LO;
        end
    end
endmodule : cbma_wrap

/* File: logic/cbma_top.sv */
// Circular buffer addressing for the X and Y address generators
`timescale 1ns/1ps
module cbma_top
    import cbma_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [cbma_pkg::AW-1:0] REG_ADDR,
    input wire logic [cbma_pkg::DW-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [cbma_pkg::DW-1:0] REG_RDATA,
    input wire logic [cbma_pkg::WREG_W-1:0] XR_REG,
    input wire logic [cbma_pkg::DW-1:0] XR_ADDR,
    input wire logic [cbma_pkg::DW-1:0] XR_STEP,
    input wire logic XR_DEC,
    output logic [cbma_pkg::DW-1:0] XR_NEXT,
    input wire logic [cbma_pkg::WREG_W-1:0] XW_REG,
    input wire logic [cbma_pkg::DW-1:0] XW_ADDR,
    input wire logic [cbma_pkg::DW-1:0] XW_STEP,
    input wire logic XW_DEC,
    output logic [cbma_pkg::DW-1:0] XW_NEXT,
    input wire logic [cbma_pkg::WREG_W-1:0] Y_REG,
    input wire logic [cbma_pkg::DW-1:0] Y_ADDR,
    input wire logic [cbma_pkg::DW-1:0] Y_STEP,
    input wire logic Y_DEC,
    output logic [cbma_pkg::DW-1:0] Y_NEXT,
    output logic X_ACTIVE,
    output logic Y_ACTIVE
);
    import cbma_pkg::*;

    logic [15:0] control_reg, control_next;
    logic [15:0] x_start_reg, x_start_next;
    logic [15:0] x_end_reg, x_end_next;
    logic [15:0] y_start_reg, y_start_next;
    logic [15:0] y_end_reg, y_end_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [2:0] wraps_reg, wraps_next;
    logic [3:0] x_pointer_select, y_pointer_select;
    logic x_circular_enable, y_circular_enable;
    logic x_on, y_on, xr_hit, xw_hit, y_hit;
    logic [15:0] xr_calc, xw_calc, y_calc;
    cbma_wrap_t xr_kind, xw_kind, y_kind;

    // Control field decode
    assign x_pointer_select = control_reg[X_SEL_LSB +: 4];
    assign y_pointer_select = control_reg[Y_SEL_LSB +: 4];
    assign x_circular_enable = control_reg[X_EN_BIT];
    assign y_circular_enable = control_reg[Y_EN_BIT];
    assign x_on = x_circular_enable && (x_pointer_select != SEL_NONE);
    assign y_on = y_circular_enable && (y_pointer_select != SEL_NONE);
    assign xr_hit = x_on && (XR_REG == x_pointer_select);
    assign xw_hit = x_on && (XW_REG == x_pointer_select);
    assign y_hit = y_on && (Y_REG == y_pointer_select);

    // one X buffer shared by both X generators
    cbma_wrap #(.W(16)) u_xr (
        .cur_addr(XR_ADDR), .step(XR_STEP), .dec(XR_DEC), .active(xr_hit), .word_only(1'b0),
        .buf_start(x_start_reg), .buf_end(x_end_reg), .new_addr(xr_calc), .wrap_kind(xr_kind)
    );
    cbma_wrap #(.W(16)) u_xw (
        .cur_addr(XW_ADDR), .step(XW_STEP), .dec(XW_DEC), .active(xw_hit), .word_only(1'b0),
        .buf_start(x_start_reg), .buf_end(x_end_reg), .new_addr(xw_calc), .wrap_kind(xw_kind)
    );
    cbma_wrap #(.W(16)) u_y (
        .cur_addr(Y_ADDR), .step(Y_STEP), .dec(Y_DEC), .active(y_hit), .word_only(1'b1),
        .buf_start(y_start_reg), .buf_end(y_end_reg), .new_addr(y_calc), .wrap_kind(y_kind)
    );

    // Next addresses are combinational so the core sees them in the same cycle
    assign XR_NEXT = xr_calc;
    assign XW_NEXT = xw_calc;
    assign Y_NEXT = y_calc;
    assign X_ACTIVE = x_on;
    assign Y_ACTIVE = y_on;

    // Register writes, reads and sticky wrap status
    always_comb begin
        control_next = control_reg;
        x_start_next = x_start_reg;
        x_end_next = x_end_reg;
        y_start_next = y_start_reg;
        y_end_next = y_end_reg;
        rdata_next = ZERO16;
        wraps_next = wraps_reg;
        if (REG_RD && REG_ADDR == REG_STATUS) begin
            wraps_next = 3'h0; // Read clears status
        end
        // Hardware set wins over the read clear
        wraps_next = wraps_next | {y_kind != CBMA_IDLE, xw_kind != CBMA_IDLE, xr_kind != CBMA_IDLE};
        if (REG_WR) begin
            case (REG_ADDR)
                REG_CONTROL: control_next = REG_WDATA & CONTROL_MASK;
                REG_X_START: x_start_next = REG_WDATA;
                REG_X_END: x_end_next = REG_WDATA;
                REG_Y_START: y_start_next = REG_WDATA;
                REG_Y_END: y_end_next = REG_WDATA;
                default: ;
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                REG_CONTROL: rdata_next = control_reg;
                REG_X_START: rdata_next = x_start_reg;
                REG_X_END: rdata_next = x_end_reg;
                REG_Y_START: rdata_next = y_start_reg;
                REG_Y_END: rdata_next = y_end_reg;
                REG_STATUS: rdata_next = {11'h000, y_on, x_on, wraps_reg};
                default: rdata_next = ZERO16;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            control_reg <= CONTROL_RST;
            x_start_reg <= ADDR_RST;
            x_end_reg <= ADDR_RST;
            y_start_reg <= ADDR_RST;
            y_end_reg <= ADDR_RST;
            rdata_reg <= ZERO16;
            wraps_reg <= 3'h0;
        end else begin
            control_reg <= control_next;
            x_start_reg <= x_start_next;
            x_end_reg <= x_end_next;
            y_start_reg <= y_start_next;
            y_end_reg <= y_end_next;
            rdata_reg <= rdata_next;
            wraps_reg <= wraps_next;
        end
    end

    assign REG_RDATA = rdata_reg;

    // Checks
    x_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (x_pointer_select == SEL_NONE) |-> !X_ACTIVE) else $error("X active with select all ones");
    x_enable_a: assert property (@(posedge REF_CLK) disable iff (RST)
        X_ACTIVE == (control_reg[X_EN_BIT] && control_reg[X_SEL_LSB +: 4] != SEL_NONE))
        else $error("X enable decode wrong");
    y_enable_a: assert property (@(posedge REF_CLK) disable iff (RST)
        Y_ACTIVE == (control_reg[Y_EN_BIT] && control_reg[Y_SEL_LSB +: 4] != SEL_NONE))
        else $error("Y enable decode wrong");
    // Word lane wraps to an aligned start, never to an odd byte
    y_wrap_hi_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (y_hit && !Y_DEC && Y_ADDR == (y_end_reg & WORD_MASK) && Y_STEP == 16'h0002 && y_end_reg[15:1] != 15'h7fff)
        |-> Y_NEXT == (y_start_reg & WORD_MASK)) else $error("Y did not reload start");
    // Sticky status: an X read wrap is always recorded, even beside a clearing read
    wrap_flag_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (xr_kind != CBMA_IDLE) |=> wraps_reg[0]) else $error("X read wrap not recorded");
    y_word_a: assert property (@(posedge REF_CLK) disable iff (RST)
        Y_NEXT[0] == 1'b0) else $error("Y address not word aligned");
    x_wrap_hi_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (xr_hit && !XR_DEC && XR_ADDR == x_end_reg && XR_STEP == 16'h0001 && x_end_reg != 16'hffff)
        |-> XR_NEXT == x_start_reg) else $error("X read did not reload start");
    x_wrap_lo_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (xw_hit && XW_DEC && XW_ADDR == x_start_reg && XW_STEP == 16'h0001 && x_start_reg != 16'h0000)
        |-> XW_NEXT == x_end_reg) else $error("X write did not reload end");
    pass_thru_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (!xr_hit && !XR_DEC) |-> XR_NEXT == XR_ADDR + XR_STEP) else $error("Unselected pointer altered");
    bound_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (REG_WR && REG_ADDR == REG_X_END) |=> x_end_reg == $past(REG_WDATA)) else $error("X end not stored");
    read_lat_a: assert property (@(posedge REF_CLK) disable iff (RST)
        (REG_RD && REG_ADDR == REG_Y_START) |=> REG_RDATA == y_start_reg) else $error("Read data late");
    x_wrap_c: cover property (@(posedge REF_CLK) disable iff (RST) xr_kind == CBMA_WRAP_HI);
    y_wrap_c: cover property (@(posedge REF_CLK) disable iff (RST) y_kind == CBMA_WRAP_LO);
    xw_wrap_c: cover property (@(posedge REF_CLK) disable iff (RST) xw_kind == CBMA_WRAP_HI);
endmodule : cbma_top

/* File: verif/cbma_agu_model.sv */
// Core pointer register that walks one address generator lane
`timescale 1ns/1ps
module cbma_agu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic adv,
    input wire logic [15:0] next_in,
    output logic [15:0] ptr
);
    logic [15:0] ptr_reg;
    logic [15:0] ptr_next;
    always_comb begin
        ptr_next = ptr_reg;
        if (load) begin
            ptr_next = load_val;
        end else if (adv) begin
            ptr_next = next_in; // Takes the wrapped value back as the core would
        end
    end
    // Pointer register, cleared by reset
    always_ff @(posedge clk) begin
        ptr_reg <= rst ? 16'h0000 : ptr_next;
    end
    assign ptr = ptr_reg;
endmodule : cbma_agu_model

/* File: verif/circular_buffer_modulo_addressing_bench.sv */
// Self-checking bench for the circular buffer addressing block
`timescale 1ns/1ps
module circular_buffer_modulo_addressing_bench;
    import cbma_pkg::*;
    typedef struct {logic [15:0] ctl; logic [3:0] sel; logic dec; logic [15:0] step, xa, xe, ya, ye;} cbma_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] sel = 4'h1;
    logic dec = 1'b0;
    logic load = 1'b0;
    logic adv = 1'b0;
    logic [15:0] step = 16'h0002, xa = 16'h0000, ya = 16'h0000, e;
    logic [15:0] reg_rdata, xr_next, xw_next, y_next, xw_addr;
    logic x_active, y_active;
    int n_mismatch = 0;
    int samples_checked = 0;
    cbma_row_t rows [9];
    // 40 MHz reference clock
    always #12.5 ref_clk = ~ref_clk;
    cbma_top dut (.REF_CLK(ref_clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .XR_REG(sel), .XR_ADDR(xa), .XR_STEP(step), .XR_DEC(dec),
        .XR_NEXT(xr_next), .XW_REG(sel), .XW_ADDR(xw_addr), .XW_STEP(step), .XW_DEC(dec), .XW_NEXT(xw_next),
        .Y_REG(sel), .Y_ADDR(ya), .Y_STEP(step), .Y_DEC(dec), .Y_NEXT(y_next), .X_ACTIVE(x_active),
        .Y_ACTIVE(y_active));
    // Core model owns the X write pointer
    cbma_agu_model core (.clk(ref_clk), .rst(rst), .load(load), .load_val(16'h1110), .adv(adv),
        .next_in(xw_next), .ptr(xw_addr));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Bus cycles change on the rising edge by non-blocking assignment
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk("read_data", reg_rdata, exp);
    endtask : rd
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    // Hang guard, far beyond the about 120 cycles the tests need
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        rows = '{'{16'hc011, 4'h1, 1'b0, 16'h2, 16'h1162, 16'h1100, 16'h203e, 16'h2000},
            '{16'hc011, 4'h1, 1'b0, 16'h2, 16'h1110, 16'h1112, 16'h2011, 16'h2012},
            '{16'hc011, 4'h1, 1'b1, 16'h2, 16'h1100, 16'h1162, 16'h2000, 16'h203e},
            '{16'hc0e1, 4'h1, 1'b1, 16'h4, 16'h1100, 16'h1160, 16'h2010, 16'h200c},
            '{16'h00ff, 4'h1, 1'b0, 16'h2, 16'h1163, 16'h1165, 16'h203e, 16'h2040},
            '{16'h80ff, 4'h1, 1'b0, 16'h2, 16'h1163, 16'h1165, 16'h203e, 16'h2040},
            '{16'h0011, 4'h1, 1'b0, 16'h2, 16'h1163, 16'h1165, 16'h203e, 16'h2040},
            '{16'hc022, 4'h1, 1'b0, 16'h2, 16'h1163, 16'h1165, 16'h203e, 16'h2040},
            '{16'hc011, 4'h1, 1'b0, 16'h2, 16'h1110, 16'h1112, 16'h2010, 16'h2012}};
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(REG_CONTROL, CONTROL_RST);
        rd(REG_X_END, ADDR_RST);
        rd(3'h7, ZERO16);
        wr(REG_X_START, 16'h1100);
        wr(REG_X_END, 16'h1163);
        wr(REG_Y_START, 16'h2000);
        wr(REG_Y_END, 16'h203f);
        rd(REG_X_END, 16'h1163);
        wr(REG_CONTROL, 16'hffff);
        rd(REG_CONTROL, 16'hc0ff);
        // Read data must drop again after its one cycle
        @(negedge ref_clk);
        chk("read_data_after", reg_rdata, ZERO16);
        $display("register tests done");
        // Table rows: control word, lane inputs and next addresses
        foreach (rows[i]) begin
            wr(REG_CONTROL, rows[i].ctl);
            sel <= rows[i].sel;
            dec <= rows[i].dec;
            step <= rows[i].step;
            xa <= rows[i].xa;
            ya <= rows[i].ya;
            @(negedge ref_clk);
            chk("x_read_next", xr_next, rows[i].xe);
            chk("y_next", y_next, rows[i].ye);
            chk("x_active", {15'h0, x_active}, {15'h0, rows[i].ctl[15] && rows[i].ctl[3:0] != SEL_NONE});
            chk("y_active", {15'h0, y_active}, {15'h0, rows[i].ctl[14] && rows[i].ctl[7:4] != SEL_NONE});
        end
        $display("table tests done");
        // Core walks the X write pointer around a 50 word buffer
        @(posedge ref_clk);
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        adv <= 1'b1;
        e = 16'h1110;
        repeat (60) begin
            @(negedge ref_clk);
            chk("x_write_pointer", xw_addr, e);
            e = e + 16'h0002;
            if (e > 16'h1163) e = e - 16'h0064;
        end
        @(posedge ref_clk);
        adv <= 1'b0;
        $display("pointer walk done");
        // Every lane wrapped earlier; both spaces on; second read sees only the live bits
        rd(REG_STATUS, 16'h001f);
        rd(REG_STATUS, 16'h0018);
        // Second reset in mid-run restores the register defaults
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(REG_CONTROL, CONTROL_RST);
        rd(REG_Y_END, ADDR_RST);
        $display("reset test done");
        test_done();
    end
endmodule : circular_buffer_modulo_addressing_bench
